// ---- cvf_formatter.sv ----
// Camera video output formatter: timing, byte sequencing and APB registers
//
// What this block does
// [RULE1] Quarter-resolution mode halves the pixel rate
// [RULE2] Quarter mode defaults 176x144, size stays programmable
// [RULE3] 16-bit: luma per pixel, chroma alternates U V
// [RULE4] 8-bit YUV: Cb Y Cr Y, luma port, double rate
// [RULE5] Nibble mode uses luma bits 7..4 only
// [RULE6] Nibble clock x2 mono, x4 color
// [RULE7] 704 mode doubles clock, repeats every sample
// [RULE8] Drive frame sync, line valid, clock, field, hsync
// [RULE9] RGB 16-bit: G R on luma, B G chroma
// [RULE10] RGB 8-bit: B G R G, chroma port off
// [RULE11] 656 mode: start/end codes around active window
// [RULE12] 8-bit RGB also available without codes
// [RULE13] 656 output 8 bits, codes carry sync
// [RULE14] U/V swap: V U 16-bit, V Y U Y 8-bit
// [RULE15] Luma/chroma swap only in 8-bit: Y U Y V
// [RULE16] RGB U/V swap exchanges B/R between rows
// [RULE17] Mono: luma only, chroma tri-stated, 16-bit rate
// [RULE18] Bit reversal mirrors the output byte
// [RULE19] Host selects formats over configuration interface
// [RULE20] Pixel bytes never 0 or 255
// [RULE21] Data valid at pixel clock rising edge
// [RULE22] Line valid only inside programmed window
// [RULE23] Inactive chroma port is high impedance
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module cvf_formatter
  import cvf_pkg::*;
#(
  parameter int H_TOTAL   = H_TOTAL_DEF,
  parameter int V_TOTAL   = V_TOTAL_DEF,
  parameter int BASE_LOG2 = BASE_LOG2_DEF
) (
  input  wire logic        ref_clk,             // System clock, 50 MHz
  input  wire logic        rst,                 // Synchronous reset, active high
  input  wire logic        psel,                // APB select
  input  wire logic        penable,             // APB enable
  input  wire logic        pwrite,              // APB write
  input  wire logic [7:0]  paddr,               // APB byte address
  input  wire logic [31:0] pwdata,              // APB write data
  output logic      [31:0] prdata,              // APB read data
  output logic             pready,              // APB ready
  output logic             pslverr,             // APB error on unmapped address
  input  wire logic [7:0]  src_y,               // Luma or G/R sample of pixel
  input  wire logic [7:0]  src_cb,              // Cb or B/G sample of pixel
  input  wire logic [7:0]  src_cr,              // Cr sample of pixel pair
  output logic             src_take,            // Pulse: source pixel consumed
  output logic      [7:0]  luma_port,           // Luma data port
  output logic      [7:0]  chroma_port,         // Chroma data port
  output logic             chroma_oe_n,         // Chroma output enable, low drives
  output logic             pix_clk,             // Pixel clock to capture side
  output logic             line_valid,          // Active line window
  output logic             frame_sync,          // Vertical sync
  output logic             odd_field_flag,      // Field toggles each frame
  output logic             composite_hsync_out  // Composite horizontal sync
);

  localparam int CW = BASE_LOG2 + 2;
  if (BASE_LOG2 < 4 || BASE_LOG2 > 6) begin : g_chk_base
    $error("BASE_LOG2 must be 4 to 6");
  end
  if (H_TOTAL < 8 || H_TOTAL > 65535 || V_TOTAL < 8 || V_TOTAL > 65535) begin : g_chk_tot
    $error("H_TOTAL and V_TOTAL must be 8 to 65535");
  end
  localparam logic [15:0] H_LAST = 16'(H_TOTAL - 1);
  localparam logic [15:0] V_LAST = 16'(V_TOTAL - 1);
  function automatic logic [7:0] bit_mirror(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7 - i];
    end
    return r;
  endfunction
  function automatic logic [7:0] vid_clamp(input logic [7:0] b);
    logic [7:0] r;
    r = b;
    if (b < VID_MIN) begin
      r = VID_MIN;
    end else if (b > VID_MAX) begin
      r = VID_MAX;
    end
    return r;
  endfunction
  // Status word of an embedded code: 1 F V H and protection bits
  function automatic logic [7:0] code_xy(input logic f, input logic v, input logic h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction
  // Registers written by software
  cvf_cfg_t    ctrl_r;
  cvf_win_t    hwin_r;
  cvf_win_t    vwin_r;
  // Copies taken at frame start so a frame never changes format midway
  cvf_cfg_t    cfg_r;
  cvf_win_t    hact_r;
  cvf_win_t    vact_r;
  logic [CW-1:0] cyc_r;
  logic [15:0]   h_cnt_r;
  logic [15:0]   v_cnt_r;
  logic [7:0]    y_r;
  logic [7:0]    cb_r;
  logic [7:0]    cr_r;
  logic [31:0]   prdata_r;
  logic          pslverr_r;
  logic          pclk_r;
  logic          lv_r;
  logic          fs_r;
  logic          odd_r;
  logic          chs_r;
  logic [7:0]    luma_r;
  logic [7:0]    chroma_r;
  logic          chroma_oe_n_r;
  // ---------------------------------------------------------------- APB slave
  logic        apb_setup;
  logic        apb_wr;
  logic        addr_ok;
  logic [31:0] rd_mux;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign addr_ok   = (paddr == OFF_CTRL) || (paddr == OFF_HWIN) ||
                     (paddr == OFF_VWIN) || (paddr == OFF_STAT);
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      OFF_CTRL: rd_mux[CTRL_CFG_MSB:0] = ctrl_r;
      OFF_HWIN: rd_mux = hwin_r;
      OFF_VWIN: rd_mux = vwin_r;
      OFF_STAT: begin
        rd_mux[STAT_VCNT_LSB +: 16] = v_cnt_r;
        rd_mux[STAT_LV_BIT]         = lv_r;
        rd_mux[STAT_FS_BIT]         = fs_r;
        rd_mux[STAT_ODD_BIT]        = odd_r;
      end
      default: rd_mux = '0;
    endcase
  end

  // Read data and error are settled in the setup cycle, so no wait states
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (apb_setup) begin
      prdata_r  <= rd_mux;
      pslverr_r <= !addr_ok;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = pslverr_r && psel && penable;

  // Format options come from the host through these registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r <= cvf_cfg_t'(CTRL_RST);
      hwin_r <= '{size: HSIZE_RST, start: HSTART_RST};
      vwin_r <= '{size: VSIZE_RST, start: VSTART_RST};
    end else if (apb_wr) begin
      if (paddr == OFF_CTRL) begin
        ctrl_r <= cvf_cfg_t'(pwdata[CTRL_CFG_MSB:0]);
      end
      if (paddr == OFF_HWIN) begin
        hwin_r <= cvf_win_t'(pwdata);
      end
      if (paddr == OFF_VWIN) begin
        vwin_r <= cvf_win_t'(pwdata);
      end
    end
  end

  // ---------------------------------------------------------------- Pixel timing
  logic          nib;
  logic          bsh;
  logic          wsh;
  logic [2:0]    p_log;
  logic [2:0]    slot_log;
  logic [CW-1:0] p_mask;
  logic [CW-1:0] s_mask;
  logic          pix_start;
  logic          pix_last;
  logic          slot_start;
  logic          frame_last;
  logic [CW-1:0] elem;

  always_comb begin
    nib        = (cfg_r.width == WID_NIB);                          // RULE5
    bsh        = !cfg_r.bw && (cfg_r.width != WID_16);              // RULE4 RULE17
    wsh        = cfg_r.wide;                                        // RULE7
    p_log      = 3'(BASE_LOG2) + {2'b00, cfg_r.quarter_resolution_mode}; // RULE1
    slot_log   = p_log - {2'b00, bsh} - {2'b00, nib} - {2'b00, wsh}; // RULE6
    p_mask     = CW'((1 << p_log) - 1);
    s_mask     = CW'((1 << slot_log) - 1);
    pix_start  = (cyc_r == '0);
    pix_last   = (cyc_r == p_mask);
    slot_start = ((cyc_r & s_mask) == '0);
    frame_last = pix_last && (h_cnt_r == H_LAST) && (v_cnt_r == V_LAST);
    elem       = cyc_r >> slot_log;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_r   <= '0;
      h_cnt_r <= '0;
      v_cnt_r <= '0;
    end else if (pix_last) begin
      cyc_r <= '0;
      if (h_cnt_r == H_LAST) begin
        h_cnt_r <= '0;
        v_cnt_r <= (v_cnt_r == V_LAST) ? 16'h0000 : v_cnt_r + 16'h0001;
      end else begin
        h_cnt_r <= h_cnt_r + 16'h0001;
      end
    end else begin
      cyc_r <= cyc_r + CW'(1);
    end
  end

  // Frame-start capture of format and window
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_r  <= cvf_cfg_t'(CTRL_RST);
      hact_r <= '{size: HSIZE_RST, start: HSTART_RST};
      vact_r <= '{size: VSIZE_RST, start: VSTART_RST};
      odd_r  <= 1'b0;
    end else if (frame_last) begin
      cfg_r  <= ctrl_r;
      hact_r <= hwin_r;
      vact_r <= vwin_r;
      odd_r  <= !odd_r;
    end
  end

  // ---------------------------------------------------------------- Windows
  logic [15:0] h_size;
  logic [15:0] v_size;
  logic [15:0] h_end;
  logic [15:0] v_end;
  logic [15:0] h_rel;
  logic        h_act;
  logic        v_act;
  logic        lv_now;
  logic        vs_now;
  logic        hs_now;

  always_comb begin
    // Quarter mode halves the programmed size, so 352x288 gives 176x144
    h_size = cfg_r.quarter_resolution_mode ? {1'b0, hact_r.size[15:1]} : hact_r.size;  // RULE2
    v_size = cfg_r.quarter_resolution_mode ? {1'b0, vact_r.size[15:1]} : vact_r.size;  // RULE2
    h_end  = hact_r.start + h_size;
    v_end  = vact_r.start + v_size;
    h_rel  = h_cnt_r - hact_r.start;
    h_act  = (h_cnt_r >= hact_r.start) && (h_cnt_r < h_end);
    v_act  = (v_cnt_r >= vact_r.start) && (v_cnt_r < v_end);
    lv_now = h_act && v_act;                                        // RULE22
    vs_now = (v_cnt_r < VSYNC_LINES);
    hs_now = (h_cnt_r < HSYNC_PIX);
  end

  // Source pixel handshake, one pulse per active pixel
  assign src_take = lv_now && pix_start;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      y_r  <= '0;
      cb_r <= '0;
      cr_r <= '0;
    end else if (src_take) begin
      y_r  <= src_y;
      cb_r <= src_cb;
      cr_r <= src_cr;
    end
  end

  // ---------------------------------------------------------------- Byte sequencing
  logic [7:0]    cur_y;
  logic [7:0]    cur_cb;
  logic [7:0]    cur_cr;
  logic          px_odd;
  logic          ln_odd;
  logic [CW-1:0] e2;
  logic          byte_i;
  logic          nib_lo;
  logic [7:0]    y_smp;
  logic [7:0]    c_smp;
  logic [7:0]    strm;
  logic          is_code;
  logic          in_sav;
  logic          in_eav;
  logic [2:0]    code_k;
  logic [7:0]    lum_b;
  logic [7:0]    lum_out;
  logic          chroma_on;

  always_comb begin
    cur_y   = src_take ? src_y : y_r;
    cur_cb  = src_take ? src_cb : cb_r;
    cur_cr  = src_take ? src_cr : cr_r;
    px_odd  = h_rel[0];
    ln_odd  = v_cnt_r[0] ^ vact_r.start[0];
    e2      = elem >> wsh;                                          // RULE7
    byte_i  = nib ? e2[1] : e2[0];
    nib_lo  = nib && e2[0];
    if (cfg_r.rgb) begin
      // Swapping channels on alternate rows exchanges the B and R rows
      y_smp = (cfg_r.uv_swap && ln_odd) ? cur_cb : cur_y;           // RULE16
      c_smp = (cfg_r.uv_swap && ln_odd) ? cur_y : cur_cb;           // RULE16 RULE9
    end else begin
      y_smp = cur_y;                                                // RULE3
      c_smp = (px_odd ^ cfg_r.uv_swap) ? cur_cr : cur_cb;           // RULE3 RULE14
    end
    // Two bytes per pixel on the luma port for 8-bit style streams
    if (cfg_r.bw) begin
      strm = y_smp;                                                 // RULE17
    end else if (cfg_r.width == WID_16) begin
      strm = y_smp;
    end else if (cfg_r.rgb) begin
      strm = (byte_i ^ px_odd) ? y_smp : c_smp;                     // RULE10 RULE12
    end else if (cfg_r.yc_swap) begin
      strm = byte_i ? c_smp : y_smp;                                // RULE15
    end else begin
      strm = byte_i ? y_smp : c_smp;                                // RULE4 RULE14
    end
    // Embedded codes fill the two pixel slots either side of the window
    in_sav  = (h_cnt_r + 16'h0002 >= hact_r.start) && (h_cnt_r < hact_r.start);
    in_eav  = (h_cnt_r >= h_end) && (h_cnt_r < h_end + 16'h0002);
    is_code = (cfg_r.width == WID_656) && !cfg_r.bw && (in_sav || in_eav); // RULE11 RULE13
    code_k  = {1'b0, in_sav ? (hact_r.start[0] ^ h_cnt_r[0]) : (h_cnt_r[0] ^ h_end[0]), byte_i};
    lum_b   = LUMA_BLANK;
    if (is_code) begin
      unique case (code_k[1:0])
        2'h0: lum_b = CODE_FF;                                      // RULE11
        2'h1: lum_b = CODE_00;
        2'h2: lum_b = CODE_00;
        2'h3: lum_b = code_xy(odd_r, !v_act, in_eav);               // RULE11
      endcase
    end else if (lv_now) begin
      lum_b = vid_clamp(strm);                                      // RULE20
    end
    lum_b   = cfg_r.bit_rev ? bit_mirror(lum_b) : lum_b;            // RULE18
    if (nib) begin
      lum_out = {nib_lo ? lum_b[3:0] : lum_b[7:4], 4'h0};           // RULE5
    end else begin
      lum_out = lum_b;
    end
    chroma_on = (cfg_r.width == WID_16) && !cfg_r.bw;               // RULE17 RULE23
  end

  // ---------------------------------------------------------------- Output stage
  // Data moves while the clock is low, so it is stable at its rising edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pclk_r <= 1'b0;
    end else begin
      pclk_r <= cyc_r[slot_log - 3'd1];                             // RULE21 RULE6
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      luma_r        <= '0;
      chroma_r      <= '0;
      chroma_oe_n_r <= 1'b1;
    end else if (slot_start) begin
      luma_r        <= lum_out;                                     // RULE21
      chroma_oe_n_r <= !chroma_on;                                  // RULE23 RULE10
      if (!chroma_on) begin
        chroma_r <= '0;
      end else if (lv_now) begin
        chroma_r <= cfg_r.bit_rev ? bit_mirror(vid_clamp(c_smp)) : vid_clamp(c_smp); // RULE9 RULE18 RULE20
      end else begin
        chroma_r <= LUMA_BLANK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lv_r  <= 1'b0;
      fs_r  <= 1'b0;
      chs_r <= 1'b0;
    end else if (pix_start) begin
      lv_r  <= lv_now;                                              // RULE22 RULE8
      fs_r  <= vs_now;                                              // RULE8
      chs_r <= hs_now ^ vs_now;                                     // RULE8
    end
  end

  assign pix_clk             = pclk_r;                              // RULE8
  assign line_valid          = lv_r;
  assign frame_sync          = fs_r;
  assign odd_field_flag      = odd_r;                               // RULE8
  assign composite_hsync_out = chs_r;
  assign luma_port           = luma_r;
  assign chroma_port         = chroma_r;
  assign chroma_oe_n         = chroma_oe_n_r;

endmodule

// ---- cvf_pkg.sv ----
// Shared constants, types and register map of the camera video output formatter
package cvf_pkg;

  // APB register byte offsets
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_HWIN       = 8'h04;
  localparam logic [7:0]  OFF_VWIN       = 8'h08;
  localparam logic [7:0]  OFF_STAT       = 8'h0C;

  // Field positions
  localparam int          CTRL_CFG_MSB   = 8;
  localparam int          WIN_START_LSB  = 0;
  localparam int          WIN_SIZE_LSB   = 16;
  localparam int          STAT_VCNT_LSB  = 0;
  localparam int          STAT_LV_BIT    = 16;
  localparam int          STAT_FS_BIT    = 17;
  localparam int          STAT_ODD_BIT   = 18;

  // Reset values
  localparam logic [8:0]  CTRL_RST       = 9'h000;
  localparam logic [15:0] HSTART_RST     = 16'h0020;
  localparam logic [15:0] HSIZE_RST      = 16'h0160;
  localparam logic [15:0] VSTART_RST     = 16'h000C;
  localparam logic [15:0] VSIZE_RST      = 16'h0120;

  // Frame timing, in pixels, lines and log2 of clocks per pixel
  localparam int          H_TOTAL_DEF    = 400;
  localparam int          V_TOTAL_DEF    = 312;
  localparam int          BASE_LOG2_DEF  = 4;
  localparam logic [15:0] HSYNC_PIX      = 16'h0010;
  localparam logic [15:0] VSYNC_LINES    = 16'h0003;

  // Video levels and embedded sync code bytes
  localparam logic [7:0]  VID_MIN        = 8'h01;
  localparam logic [7:0]  VID_MAX        = 8'hFE;
  localparam logic [7:0]  LUMA_BLANK     = 8'h10;
  localparam logic [7:0]  CODE_FF        = 8'hFF;
  localparam logic [7:0]  CODE_00        = 8'h00;

  typedef enum logic [1:0] {
    WID_16  = 2'h0,
    WID_8   = 2'h1,
    WID_NIB = 2'h2,
    WID_656 = 2'h3
  } cvf_width_t;

  // Control register layout, bit 8 downward
  typedef struct packed {
    logic       wide;
    logic       quarter_resolution_mode;
    logic       bit_rev;
    logic       bw;
    logic       yc_swap;
    logic       uv_swap;
    logic       rgb;
    cvf_width_t width;
  } cvf_cfg_t;

  typedef struct packed {
    logic [15:0] size;
    logic [15:0] start;
  } cvf_win_t;

endpackage

// ---- cvf_formatter_chk.sv ----
// Port assertions of the camera video output formatter
`timescale 1ns/1ps
module cvf_formatter_chk
  import cvf_pkg::*;
#(
  parameter int H_TOTAL   = H_TOTAL_DEF,
  parameter int V_TOTAL   = V_TOTAL_DEF,
  parameter int BASE_LOG2 = BASE_LOG2_DEF
) (
  input wire logic       ref_clk,            // Clock
  input wire logic       rst,                // Reset
  input wire logic       src_take,           // Pixel taken
  input wire logic [7:0] luma_port,          // Luma
  input wire logic [7:0] chroma_port,        // Chroma
  input wire logic       chroma_oe_n,        // Chroma off
  input wire logic       pix_clk,            // Pixel clock
  input wire logic       line_valid,         // Window
  input wire logic       frame_sync,         // Vsync
  input wire logic       odd_field_flag,     // Field
  input wire logic       composite_hsync_out // Hsync
);
  localparam int PIX    = 1 << BASE_LOG2;
  localparam int FS_LEN = 3 * H_TOTAL * PIX;
  logic [23:0] fs_cnt_r;
  logic [23:0] take_gap_r;
  default clocking chk_cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Sync length and pixel spacing exceed any repetition count
  always_ff @(posedge ref_clk) begin
    if (rst || !frame_sync) fs_cnt_r <= 24'h0;
    else fs_cnt_r <= fs_cnt_r + 24'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (rst || src_take) take_gap_r <= 24'h1;
    else take_gap_r <= take_gap_r + 24'h1;
  end
  property p_lv_after_take;
    $rose(line_valid) |-> $past(src_take);
  endproperty
  a_lv_after_take: assert property (p_lv_after_take) else $error("line valid rose without a pixel");
  property p_take_rate;
    src_take && line_valid |-> take_gap_r == PIX || take_gap_r == 2 * PIX;
  endproperty
  a_take_rate: assert property (p_take_rate) else $error("pixel spacing wrong");
  property p_chroma_off;
    chroma_oe_n |-> chroma_port == 8'h00;
  endproperty
  a_chroma_off: assert property (p_chroma_off) else $error("chroma data while released");
  property p_no_reserved;
    line_valid |-> luma_port != 8'hFF && chroma_port != 8'hFF;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved byte in window");
  property p_data_stable;
    $rose(pix_clk) |-> $stable(luma_port) && $stable(chroma_port);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved at clock rise");
  property p_hsync_window;
    line_valid && !frame_sync |-> !composite_hsync_out;
  endproperty
  a_hsync_window: assert property (p_hsync_window) else $error("hsync inside window");
  property p_fs_len;
    $fell(frame_sync) |-> fs_cnt_r == FS_LEN || fs_cnt_r == 2 * FS_LEN;
  endproperty
  a_fs_len: assert property (p_fs_len) else $error("frame sync length wrong");
  property p_odd_toggle;
    $changed(odd_field_flag) |=> frame_sync;
  endproperty
  a_odd_toggle: assert property (p_odd_toggle) else $error("field flag moved mid frame");
  c_line: cover property ($rose(line_valid));
  c_mono: cover property (line_valid && chroma_oe_n);
  c_frame: cover property ($fell(frame_sync));
endmodule

bind cvf_formatter cvf_formatter_chk #(
  .H_TOTAL(H_TOTAL), .V_TOTAL(V_TOTAL), .BASE_LOG2(BASE_LOG2)
) i_cvf_formatter_chk (
  .ref_clk, .rst, .src_take, .luma_port, .chroma_port, .chroma_oe_n,
  .pix_clk, .line_valid, .frame_sync, .odd_field_flag, .composite_hsync_out
);

// ---- cvf_capture_model.sv ----
// Capture controller model latching the video ports at pixel clock rises
`timescale 1ns/1ps
module cvf_capture_model (
  input  wire logic        ref_clk,      // Clock
  input  wire logic        rst,          // Reset
  input  wire logic        pix_clk,      // Pixel clock
  input  wire logic        line_valid,   // Window
  input  wire logic [7:0]  luma_port,    // Luma
  input  wire logic [7:0]  chroma_port,  // Chroma
  input  wire logic        chroma_oe_n,  // Chroma off
  output logic      [31:0] first_luma,   // First luma bytes
  output logic      [15:0] first_chroma, // First chroma bytes
  output logic      [31:0] pre_code,     // Bytes before window
  output logic      [15:0] line_bytes,   // Bytes of last line
  output logic      [7:0]  pix_period,   // Cycles per clock
  output logic             line_done     // End of line
);
  logic        pclk_d;
  logic        lv_d;
  logic [7:0]  chroma_last;
  logic [7:0]  chroma_pin;
  logic [7:0]  gap;
  logic [31:0] hist;
  logic [15:0] cnt;
  // Released port floats: show the inverse of its last byte
  assign chroma_pin = chroma_oe_n ? ~chroma_last : chroma_port;
  always_ff @(posedge ref_clk) begin
    line_done <= 1'b0;
    if (rst) begin
      {pclk_d, lv_d, chroma_last, gap, hist, cnt} <= '0;
      {first_luma, first_chroma, pre_code, line_bytes, pix_period} <= '0;
    end else begin
      pclk_d <= pix_clk;
      lv_d <= line_valid;
      gap <= gap + 8'h1;
      if (!chroma_oe_n) chroma_last <= chroma_port;
      if (pix_clk && !pclk_d) begin
        gap <= 8'h1;
        hist <= {hist[23:0], luma_port};
        if (line_valid) begin
          pix_period <= gap;
          cnt <= cnt + 16'h1;
          if (cnt == 16'h0) begin
            pre_code <= hist;
            first_luma <= {24'h0, luma_port};
            first_chroma <= {8'h0, chroma_pin};
          end else begin
            if (cnt < 16'h4) first_luma <= {first_luma[23:0], luma_port};
            if (cnt < 16'h2) first_chroma <= {first_chroma[7:0], chroma_pin};
          end
        end
      end
      if (lv_d && !line_valid) begin
        line_bytes <= cnt;
        cnt <= 16'h0;
        line_done <= 1'b1;
      end
    end
  end
endmodule

// ---- cvf_formatter_tb_top.sv ----
// Self-checking testbench of the camera video output formatter
`timescale 1ns/1ps
module cvf_formatter_tb_top
  import cvf_pkg::*;
;
  typedef struct packed {
    cvf_cfg_t    cfg;
    logic [23:0] src;
    logic [31:0] luma;
    logic [15:0] chroma;
    logic        oe_n;
    logic [7:0]  per;
    logic [15:0] nbytes;
  } cvf_row_t;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, src_take;
  logic chroma_oe_n, pix_clk, line_valid, frame_sync, odd_field_flag, composite_hsync_out, line_done;
  logic [7:0] paddr, src_y, src_cb, src_cr, luma_port, chroma_port, pix_period;
  logic [31:0] pwdata, prdata, rdata, first_luma, pre_code;
  logic [15:0] first_chroma, line_bytes;
  logic rerr;
  int failures, compares, cycles;
  cvf_row_t rows [15];
  cvf_row_t r;

  cvf_formatter #(.H_TOTAL(24), .V_TOTAL(6), .BASE_LOG2(4)) i_cvf_formatter (.*);
  cvf_capture_model i_cvf_capture_model (.*);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Worst row needs under two short frames; the ceiling leaves margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Settings land at a frame start: let any sync under way end first
  task automatic frame();
    do @(posedge ref_clk); while (frame_sync !== 1'b0);
    do @(posedge ref_clk); while (frame_sync !== 1'b1);
    do @(posedge ref_clk); while (line_done !== 1'b1);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {src_y, src_cb, src_cr} = 24'h405060;
    rst = 1'b1;
    rows = '{
      '{9'h000, 24'h405060, 32'h40404040, 16'h5060, 1'b0, 8'h10, 16'h6},
      '{9'h001, 24'h405060, 32'h50406040, 16'h0, 1'b1, 8'h08, 16'hC},
      '{9'h009, 24'h405060, 32'h60405040, 16'h0, 1'b1, 8'h08, 16'hC},
      '{9'h011, 24'h405060, 32'h40504060, 16'h0, 1'b1, 8'h08, 16'hC},
      '{9'h008, 24'h405060, 32'h40404040, 16'h6050, 1'b0, 8'h10, 16'h6},
      '{9'h040, 24'h405060, 32'h02020202, 16'h0A06, 1'b0, 8'h10, 16'h6},
      '{9'h020, 24'h405060, 32'h40404040, 16'h0, 1'b1, 8'h10, 16'h6},
      '{9'h004, 24'h405060, 32'h40404040, 16'h5050, 1'b0, 8'h10, 16'h6},
      '{9'h005, 24'h405060, 32'h50404050, 16'h0, 1'b1, 8'h08, 16'hC},
      '{9'h022, 24'h4A5B6C, 32'h40A040A0, 16'h0, 1'b1, 8'h08, 16'hC},
      '{9'h002, 24'h4A5B6C, 32'h50B040A0, 16'h0, 1'b1, 8'h04, 16'h18},
      '{9'h100, 24'h405060, 32'h40404040, 16'h5050, 1'b0, 8'h08, 16'hC},
      '{9'h080, 24'h405060, 32'h00404040, 16'h5060, 1'b0, 8'h20, 16'h3},
      '{9'h000, 24'hFF0000, 32'hFEFEFEFE, 16'h0101, 1'b0, 8'h10, 16'h6},
      '{9'h003, 24'h405060, 32'h50406040, 16'h0, 1'b1, 8'h08, 16'hC}};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    chk("oe_n in reset", 32'h1, chroma_oe_n);
    chk("pready in reset", 32'h1, pready);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl reset", {23'h0, CTRL_RST}, rdata);
    apb(1'b0, OFF_HWIN, 32'h0);
    chk("hwin reset", {HSIZE_RST, HSTART_RST}, rdata);
    apb(1'b0, OFF_VWIN, 32'h0);
    chk("vwin reset", {VSIZE_RST, VSTART_RST}, rdata);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped write err", 32'h1, rerr);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, rdata);
    chk("unmapped read err", 32'h1, rerr);
    apb(1'b1, OFF_STAT, 32'hFFFFFFFF);
    chk("stat write err", 32'h0, rerr);
    apb(1'b1, OFF_HWIN, 32'h00060010);
    apb(1'b1, OFF_VWIN, 32'h00020003);
    apb(1'b0, OFF_HWIN, 32'h0);
    chk("hwin", 32'h00060010, rdata);
    foreach (rows[i]) begin
      r = rows[i];
      {src_y, src_cb, src_cr} <= r.src;
      apb(1'b1, OFF_CTRL, {23'h0, r.cfg});
      frame();
      chk($sformatf("luma %0d", i), r.luma, first_luma);
      if (!r.oe_n) chk($sformatf("chroma %0d", i), r.chroma, first_chroma);
      chk($sformatf("oe_n %0d", i), r.oe_n, chroma_oe_n);
      chk($sformatf("period %0d", i), r.per, pix_period);
      chk($sformatf("bytes %0d", i), r.nbytes, line_bytes);
    end
    chk("start code", 32'hFF000080, pre_code & 32'hFFFFFFB8);
    // Row swap shows on the second window line
    apb(1'b1, OFF_CTRL, 32'h0000000C);
    frame();
    do @(posedge ref_clk); while (line_done !== 1'b1);
    chk("rgb swap luma", 32'h50505050, first_luma);
    chk("rgb swap chroma", 32'h4040, first_chroma);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("oe_n second reset", 32'h1, chroma_oe_n);
    chk("lv second reset", 32'h0, line_valid);
    rst <= 1'b0;
    results();
  end
endmodule
